// File: csp_device.sv
// Device end: two-wire slave with register pointer and register file
`timescale 1ns/100ps
`default_nettype none
`include "csp_defs.svh"
module csp_device
  import csp_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'hA5  // Arbitrary value
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  csp_if.dev              link,
  output logic            soft_power_down_n_o,
  output logic            wr_stb_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic            busy_o
);
  // ==========================================================
  // Pin synchronisers and condition detection
  logic [1:0]     scl_sync;
  logic [1:0]     sda_sync;
  logic           scl_q;
  logic           sda_q;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_c;
  logic           stop_c;
  logic           start_in_high;
  logic           stop_ok;
  csp_slv_state_t state;
  logic [3:0]     bitcnt;
  logic [7:0]     shreg;
  logic [7:0]     ptr;
  logic           rw;
  logic           first_byte;
  logic           plain_start;
  logic           master_nack;
  logic           sda_oe_n;
  logic           store_now;
  logic [7:0]     regs [`CSP_NUM_REGS];
  logic [7:0]     rd_byte;

  // Two flops before any logic; both lines idle high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_q;
  assign scl_fall = ~scl_sync[1] & scl_q;
  // Data edges with clock high are conditions, not data
  assign start_c  = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop_c   = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  // STOP in the same high pulse as START is not honoured
  assign stop_ok  = stop_c & ~start_in_high & ~start_c;

  // Marks a clock-high period that already held a START
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_in_high <= 1'b0;
    end else if (start_c) begin
      start_in_high <= 1'b1;
    end else if (scl_fall) begin
      start_in_high <= 1'b0;
    end
  end

  // ==========================================================
  // Read source: register file, revision code, reserved as zero
  always_comb begin
    rd_byte = 8'h00;
    if (ptr == `CSP_REV_ADDR) begin
      rd_byte = REVISION_CODE;
    end else if (ptr <= `CSP_LAST_REG) begin
      rd_byte = regs[ptr[4:0]];
    end
  end

  // Data byte complete in receive phase, not the pointer byte
  assign store_now = (state == CSP_S_RX) & scl_fall &
                     (bitcnt == `CSP_ACK_BIT) & ~first_byte;

  // ==========================================================
  // Protocol sequencer; the clock line is never driven
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= CSP_S_IDLE;
      bitcnt      <= 4'h0;
      shreg       <= 8'h00;
      ptr         <= `CSP_PTR_RESET;
      rw          <= `CSP_RW_WRITE;
      first_byte  <= 1'b0;
      plain_start <= 1'b1;
      master_nack <= 1'b0;
      sda_oe_n    <= 1'b1;
      busy_o      <= 1'b0;
    end else if (stop_ok) begin
      // Abandon the transfer at any point and free the bus
      state    <= CSP_S_IDLE;
      sda_oe_n <= 1'b1;
      busy_o   <= 1'b0;
    end else if (start_c) begin
      // A START while busy is a repeated one: new address phase
      state       <= CSP_S_ADDR;
      bitcnt      <= 4'h0;
      sda_oe_n    <= 1'b1;
      plain_start <= ~busy_o;
      busy_o      <= 1'b1;
    end else begin
      case (state)
        CSP_S_ADDR, CSP_S_RX: begin
          if (scl_rise) begin
            // Sample at rising edge, MSB first
            shreg  <= {shreg[6:0], sda_sync[1]};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `CSP_ACK_BIT) begin
            if (state == CSP_S_ADDR) begin
              if (shreg[7:1] == `CSP_SLAVE_ADDR) begin
                sda_oe_n   <= 1'b0;
                state      <= CSP_S_ACK;
                rw         <= shreg[0];
                first_byte <= 1'b1;
                if (shreg[0] == `CSP_RW_READ && plain_start) begin
                  ptr <= `CSP_PTR_RESET;
                end
              end else begin
                state <= CSP_S_IGNORE;  // Leave line high: nack
              end
            end else begin
              sda_oe_n   <= 1'b0;
              state      <= CSP_S_ACK;
              first_byte <= 1'b0;
              if (first_byte) begin
                ptr <= shreg;
              end else begin
                ptr <= ptr + 8'h01;
              end
            end
          end
        end
        CSP_S_ACK: begin
          if (scl_fall) begin
            // Ack held to the end of the ninth pulse
            bitcnt <= 4'h0;
            if (rw == `CSP_RW_READ) begin
              shreg    <= rd_byte;
              sda_oe_n <= rd_byte[7];  // Set up before next rise
              state    <= CSP_S_TX;
            end else begin
              sda_oe_n <= 1'b1;
              state    <= CSP_S_RX;
            end
          end
        end
        CSP_S_TX: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == `CSP_ACK_BIT) begin
              sda_oe_n <= 1'b1;  // Master owns the ack slot
              ptr      <= ptr + 8'h01;
              state    <= CSP_S_MACK;
            end else begin
              // Changes only with clock low, stable while high
              shreg    <= {shreg[6:0], 1'b0};
              sda_oe_n <= shreg[6];
            end
          end
        end
        CSP_S_MACK: begin
          if (scl_rise) begin
            master_nack <= sda_sync[1];
          end else if (scl_fall) begin
            if (!master_nack) begin
              // Master acked: continue with the next register
              bitcnt   <= 4'h0;
              shreg    <= rd_byte;
              sda_oe_n <= rd_byte[7];
              state    <= CSP_S_TX;
            end else begin
              state <= CSP_S_IGNORE;  // Wait for STOP or START
            end
          end
        end
        CSP_S_IDLE, CSP_S_IGNORE: begin
          sda_oe_n <= 1'b1;
        end
        default: begin
          state    <= CSP_S_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Register file; reserved locations above the map drop writes
  // Kept live regardless of the shutdown bit
  for (genvar i = 0; i < `CSP_NUM_REGS; i++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        regs[i] <= `CSP_REG_RESET;
      end else if (store_now && ptr == 8'(i)) begin
        regs[i] <= shreg;
      end
    end
  end

  // User-side view of writes and the shutdown bit, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_stb_o            <= 1'b0;
      wr_addr_o           <= 8'h00;
      wr_data_o           <= 8'h00;
      soft_power_down_n_o <= 1'b0;
    end else begin
      wr_stb_o            <= store_now && ptr <= `CSP_LAST_REG;
      soft_power_down_n_o <= regs[`CSP_PWR_REG][`CSP_PWR_BIT];
      if (store_now) begin
        wr_addr_o <= ptr;
        wr_data_o <= shreg;
      end
    end
  end

  // Open drain: only ever pulls low, enable low while driving
  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = sda_oe_n;
endmodule : csp_device
`default_nettype wire

// File: csp_defs.svh
// Constants shared by both ends of the serial control port
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
`define CSP_SLAVE_ADDR 7'h10
`define CSP_RW_READ    1'b1
`define CSP_RW_WRITE   1'b0
`define CSP_PTR_RESET  8'h00
`define CSP_LAST_REG   8'h10
`define CSP_REV_ADDR   8'hFF
`define CSP_NUM_REGS   17
`define CSP_REG_RESET  8'h00
`define CSP_PWR_REG    5'h10
`define CSP_PWR_BIT    7
`define CSP_ACK_BIT    4'h8
`define CSP_CLK_HZ     125000000
`define CSP_SCL_HZ     400000
`define CSP_QTR_CYC    ((`CSP_CLK_HZ + 4*`CSP_SCL_HZ - 1) / (4*`CSP_SCL_HZ))
`define CSP_MAX_RETRY  2
`endif

// File: csp_pkg.sv
// Types shared by both ends of the serial control port
`default_nettype none
package csp_pkg;
  typedef enum logic [2:0] {
    CSP_S_IDLE, CSP_S_ADDR, CSP_S_ACK, CSP_S_RX, CSP_S_TX, CSP_S_MACK,
    CSP_S_IGNORE
  } csp_slv_state_t;
  typedef enum logic [2:0] {
    CSP_M_IDLE, CSP_M_START, CSP_M_BIT, CSP_M_STOP
  } csp_mst_state_t;
endpackage : csp_pkg
`default_nettype wire

// File: csp_if.sv
// Two-wire link between controller and device, with wired-AND data line
`timescale 1ns/100ps
`default_nettype none
interface csp_if;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic mst_sda_o;
  logic mst_sda_oe_n;
  logic mst_scl_o;
  logic sda;
  logic scl;
  // Pull-up: line is high unless an enabled driver pulls it low
  assign sda = (dev_sda_oe_n | dev_sda_o) & (mst_sda_oe_n | mst_sda_o);
  assign scl = mst_scl_o;
  modport dev (input sda, input scl, output dev_sda_o, output dev_sda_oe_n);
  modport mst (input sda, output mst_sda_o, output mst_sda_oe_n,
               output mst_scl_o);
endinterface : csp_if
`default_nettype wire

// File: csp_master.sv
// Controller end: issues register writes and random reads
`timescale 1ns/100ps
`default_nettype none
`include "csp_defs.svh"
module csp_master
  import csp_pkg::*;
#(
  parameter int QTR_CYC   = `CSP_QTR_CYC,
  parameter int MAX_RETRY = `CSP_MAX_RETRY
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  csp_if.mst              link,
  input  wire logic       go_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] reg_i,
  input  wire logic [7:0] wdata_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            fail_o,
  output logic [7:0]      rdata_o
);
  // ==========================================================
  // Quarter-bit enable; 400kHz rounded down in rate
  logic [15:0]    qcnt;
  logic           tick;
  logic [1:0]     sda_sync;
  csp_mst_state_t state;
  logic [1:0]     phase;
  logic [2:0]     step;
  logic [3:0]     bitn;
  logic [7:0]     shreg;
  logic           rd_q;
  logic [7:0]     reg_q;
  logic [7:0]     wdata_q;
  logic           fail_pend;
  logic [3:0]     retries;
  logic           scl;
  logic           sda_oe_n;
  logic           tx;
  logic [7:0]     next_byte;

  always_ff @(posedge clk_i) begin
    if (rst_i || state == CSP_M_IDLE || tick) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end
  assign tick = (qcnt == 16'(QTR_CYC - 1));

  // Line read back through two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // Byte per step: address W, pointer, data or address R
  always_comb begin
    case (step)
      3'h0:    next_byte = {`CSP_SLAVE_ADDR, `CSP_RW_WRITE};
      3'h1:    next_byte = reg_q;
      3'h2:    next_byte = wdata_q;
      default: next_byte = {`CSP_SLAVE_ADDR, `CSP_RW_READ};
    endcase
  end
  assign tx = (step != 3'h4);

  // ==========================================================
  // Bit sequencer: quarters low/rise/high/fall; only we clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= CSP_M_IDLE; phase <= 2'h0; step <= 3'h0;
      bitn <= 4'h0; shreg <= 8'h00; rd_q <= 1'b0;
      reg_q <= 8'h00; wdata_q <= 8'h00; fail_pend <= 1'b0;
      retries <= 4'h0; scl <= 1'b1; sda_oe_n <= 1'b1;
      busy_o <= 1'b0; done_o <= 1'b0; fail_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (state == CSP_M_IDLE) begin
        if (go_i && !rd_i && reg_i > `CSP_LAST_REG) begin
          // Write to a reserved target: refused at once, no frame is sent
          done_o <= 1'b1;
          fail_o <= 1'b1;
        end else if (go_i) begin
          state <= CSP_M_START; phase <= 2'h0; step <= 3'h0;
          rd_q <= rd_i; reg_q <= reg_i; wdata_q <= wdata_i;
          retries <= 4'h0; fail_pend <= 1'b0; busy_o <= 1'b1;
        end
      end else if (tick) begin
        phase <= phase + 2'h1;
        case (state)
          // Same shape serves START and REPEATED START
          CSP_M_START: begin
            case (phase)
              2'h0:    sda_oe_n <= 1'b1;
              2'h1:    scl <= 1'b1;
              2'h2:    sda_oe_n <= 1'b0;
              default: begin
                scl <= 1'b0; state <= CSP_M_BIT;
                bitn <= 4'h0; shreg <= next_byte;
              end
            endcase
          end
          CSP_M_BIT: begin
            case (phase)
              2'h0: begin
                // Data changes only with clock low, MSB first
                if (bitn < `CSP_ACK_BIT) begin
                  sda_oe_n <= tx ? shreg[7] : 1'b1;
                end else begin
                  sda_oe_n <= 1'b1;  // Single read byte: nack
                end
              end
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (bitn == `CSP_ACK_BIT) begin
                  if (tx && sda_sync[1]) fail_pend <= 1'b1;
                end else if (!tx) begin
                  shreg <= {shreg[6:0], sda_sync[1]};
                end
              end
              default: begin
                scl  <= 1'b0;
                bitn <= bitn + 4'h1;
                if (tx && bitn < `CSP_ACK_BIT) shreg <= {shreg[6:0], 1'b0};
                if (bitn == `CSP_ACK_BIT) begin
                  bitn <= 4'h0;
                  if (fail_pend) begin
                    state <= CSP_M_STOP;  // Missing ack: give up
                  end else begin
                    case (step)
                      3'h0: begin step <= 3'h1; shreg <= reg_q; end
                      3'h1: begin
                        if (rd_q) begin
                          step <= 3'h3; state <= CSP_M_START;
                        end else begin
                          step <= 3'h2; shreg <= wdata_q;
                        end
                      end
                      3'h3: step <= 3'h4;
                      3'h4: begin
                        rdata_o <= shreg; state <= CSP_M_STOP;
                      end
                      default: state <= CSP_M_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
          CSP_M_STOP: begin
            case (phase)
              2'h0: sda_oe_n <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe_n <= 1'b1;  // Never in a START's high pulse
              default: begin
                if (fail_pend && retries < 4'(MAX_RETRY)) begin
                  // Retry the whole frame after a failed one
                  retries <= retries + 4'h1; fail_pend <= 1'b0;
                  step <= 3'h0; state <= CSP_M_START;
                end else begin
                  state <= CSP_M_IDLE; busy_o <= 1'b0;
                  done_o <= 1'b1; fail_o <= fail_pend;
                end
              end
            endcase
          end
          default: state <= CSP_M_IDLE;
        endcase
      end
    end
  end

  // Open-drain data line, push-pull clock line
  assign link.mst_sda_o    = 1'b0;
  assign link.mst_sda_oe_n = sda_oe_n;
  assign link.mst_scl_o    = scl;
endmodule : csp_master
`default_nettype wire

// File: csp_link_props.sv
// Checker for the controller-to-device two-wire link
`timescale 1ns/100ps
`default_nettype none
`include "csp_defs.svh"
module csp_link_props #(
  parameter int QTR_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic mst_sda_o,
  input wire logic mst_sda_oe_n,
  input wire logic mst_scl_o,
  input wire logic sda,
  input wire logic scl
);
  // ==========================================
  // Edge finding and bit counting
  logic        scl_q, sda_q, frame, rw, start_ev, stop_ev, rise, ninth;
  logic [3:0]  bit_cnt, byte_idx;
  logic [7:0]  shreg;
  logic [15:0] hold;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign rise     = scl && !scl_q;
  assign ninth    = rise && bit_cnt == 4'h8;
  // Line history; both lines idle high
  always_ff @(posedge clk_i) begin
    scl_q <= rst_i | scl;
    sda_q <= rst_i | sda;
  end
  // Bus taken between START and STOP
  always_ff @(posedge clk_i) begin
    if (rst_i) frame <= 1'b0;
    else if (start_ev) frame <= 1'b1;
    else if (stop_ev) frame <= 1'b0;
  end
  // Bit and byte position; a repeated START restarts the count
  always_ff @(posedge clk_i) begin
    if (rst_i || start_ev) begin
      bit_cnt  <= 4'h0;
      byte_idx <= 4'h0;
    end else if (rise) begin
      bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
      if (ninth && byte_idx != 4'hF) byte_idx <= byte_idx + 4'h1;
    end
  end
  // Eight data bits shifted in; the ninth pulse is the acknowledge
  always_ff @(posedge clk_i) begin
    if (rise && bit_cnt != 4'h8) shreg <= {shreg[6:0], sda};
  end
  // Direction bit of the address byte
  always_ff @(posedge clk_i) begin
    if (rst_i) rw <= 1'b0;
    else if (ninth && byte_idx == 4'h0) rw <= shreg[0];
  end
  // Cycles since the clock line last moved, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || scl != scl_q) hold <= 16'h0000;
    else if (hold != 16'hFFFF) hold <= hold + 16'h0001;
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_addr_ack;
    ninth && byte_idx == 4'h0 && shreg[7:1] == `CSP_SLAVE_ADDR
      |-> !dev_sda_oe_n;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address byte not acknowledged");
  property p_wr_ack;
    ninth && byte_idx != 4'h0 && !rw |-> !dev_sda_oe_n;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");
  property p_rd_end;
    ninth && byte_idx != 4'h0 && rw |-> dev_sda_oe_n && sda;
  endproperty
  a_rd_end: assert property (p_rd_end)
    else $error("read byte not ended by a nack");
  property p_ack_hold;
    ninth && !dev_sda_oe_n |-> !dev_sda_oe_n [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge dropped while clock high");
  // Open drain: an enabled driver only ever pulls low
  property p_no_high;
    (dev_sda_oe_n || !dev_sda_o) && (mst_sda_oe_n || !mst_sda_o);
  endproperty
  a_no_high: assert property (p_no_high)
    else $error("data line driven high");
  property p_drv_scl_low;
    $changed(dev_sda_oe_n) |-> !scl && !scl_q;
  endproperty
  a_drv_scl_low: assert property (p_drv_scl_low)
    else $error("device moved data while clock high");
  property p_idle;
    !frame |-> mst_scl_o && dev_sda_oe_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("lines not idle outside a frame");
  property p_half;
    scl != scl_q |-> hold >= QTR_CYC;
  endproperty
  a_half: assert property (p_half)
    else $error("clock half period too short");
  c_write: cover property (ninth && byte_idx == 4'h2 && !rw);
  c_read: cover property (ninth && byte_idx == 4'h1 && rw);
  c_rstart: cover property (start_ev && frame);
endmodule : csp_link_props
`default_nettype wire

// File: i2c_slave_register_port_tb_top.sv
// Testbench: controller and device on one link, bench master on another
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_register_port_tb_top;
  localparam int         QTR = 8;
  localparam logic [7:0] DEVICE_REVISION = 8'h5C;  // Arbitrary revision value
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       go = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] reg_a = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       m_busy, m_done, m_fail, pwr_n, stb_a, busy_a, stb_b, busy_b;
  logic [7:0] m_rdata, waddr_a, wdata_a, waddr_b, wdata_b, g8;
  logic       a1;
  int         stb_cnt_a = 0;
  int         stb_cnt_b = 0;
  int         fail_count = 0;
  int         n_checks = 0;
  csp_if link_a ();
  csp_if link_b ();
  // ==========================================
  // Clock, design ends and checker
  always #4 clk_i = ~clk_i;
  csp_master #(.QTR_CYC(QTR), .MAX_RETRY(2)) i_csp_master (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_a), .go_i(go), .rd_i(rd),
    .reg_i(reg_a), .wdata_i(wdata), .busy_o(m_busy), .done_o(m_done),
    .fail_o(m_fail), .rdata_o(m_rdata));
  csp_device #(.REVISION_CODE(DEVICE_REVISION)) i_csp_device (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_a),
    .soft_power_down_n_o(pwr_n), .wr_stb_o(stb_a), .wr_addr_o(waddr_a),
    .wr_data_o(wdata_a), .busy_o(busy_a));
  // Second device, driven by the bench so faults can be injected
  csp_device #(.REVISION_CODE(DEVICE_REVISION)) i_csp_device_b (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_b),
    .soft_power_down_n_o(), .wr_stb_o(stb_b), .wr_addr_o(waddr_b),
    .wr_data_o(wdata_b), .busy_o(busy_b));
  csp_link_props #(.QTR_CYC(QTR)) i_csp_link_props (
    .clk_i(clk_i), .rst_i(rst_i), .dev_sda_o(link_a.dev_sda_o),
    .dev_sda_oe_n(link_a.dev_sda_oe_n), .mst_sda_o(link_a.mst_sda_o),
    .mst_sda_oe_n(link_a.mst_sda_oe_n), .mst_scl_o(link_a.mst_scl_o),
    .sda(link_a.sda), .scl(link_a.scl));
  // Count stored bytes on each device
  always @(posedge clk_i) begin
    if (stb_a === 1'b1) stb_cnt_a <= stb_cnt_a + 1;
    if (stb_b === 1'b1) stb_cnt_b <= stb_cnt_b + 1;
  end
  // ==========================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // One controller command; the wait for done is bounded
  task automatic cmd(input logic r, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    go <= 1'b1;
    rd <= r;
    reg_a <= a;
    wdata <= d;
    @(posedge clk_i);
    go <= 1'b0;
    while (m_done !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 5000) begin
      fail_count++;
      close_out();
    end
    chk({7'h00, m_fail}, {7'h00, !r && a > 8'h10});
  endtask : cmd
  task automatic wq;
    repeat (10) @(posedge clk_i);
  endtask : wq
  // Bench master on the second link; also serves as repeated START
  task automatic bb_start;
    link_b.mst_sda_oe_n <= 1'b1;
    wq();
    link_b.mst_scl_o <= 1'b1;
    wq();
    link_b.mst_sda_oe_n <= 1'b0;
    wq();
    link_b.mst_scl_o <= 1'b0;
    wq();
  endtask : bb_start
  task automatic bb_stop;
    link_b.mst_sda_oe_n <= 1'b0;
    wq();
    link_b.mst_scl_o <= 1'b1;
    wq();
    link_b.mst_sda_oe_n <= 1'b1;
    wq();
  endtask : bb_stop
  // n clock pulses, MSB first; pulse nine carries a9 and samples ack
  task automatic bb_byte(input logic [7:0] v, input logic a9, input int n,
                         output logic [7:0] got, output logic ack);
    got = 8'h00;
    ack = 1'b1;
    for (int i = 0; i < n; i++) begin
      link_b.mst_sda_oe_n <= (i < 8) ? v[7 - i] : a9;
      wq();
      link_b.mst_scl_o <= 1'b1;
      wq();
      if (i < 8) got = {got[6:0], link_b.sda};
      else ack = link_b.sda;
      link_b.mst_scl_o <= 1'b0;
      wq();
    end
  endtask : bb_byte
  task automatic bw(input logic [7:0] v, input logic exp_ack);
    bb_byte(v, 1'b1, 9, g8, a1);
    chk({7'h00, a1}, {7'h00, exp_ack});
  endtask : bw
  task automatic br(input logic a9, input logic [7:0] exp);
    bb_byte(8'hFF, a9, 9, g8, a1);
    chk(g8, exp);
  endtask : br
  // ==========================================
  // Main sequence
  initial begin
    link_b.mst_sda_o <= 1'b0;
    link_b.mst_sda_oe_n <= 1'b1;
    link_b.mst_scl_o <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    // Write and read back while in software shutdown, then leave it through the shutdown bit
    chk({7'h00, pwr_n}, 8'h00);
    cmd(1'b0, 8'h05, 8'h3C);
    chk(8'(stb_cnt_a), 8'h01);
    chk({7'h00, m_busy}, 8'h00);
    chk(waddr_a, 8'h05);
    chk(wdata_a, 8'h3C);
    cmd(1'b1, 8'h05, 8'h00);
    chk(m_rdata, 8'h3C);
    cmd(1'b0, 8'h10, 8'h80);
    chk({7'h00, pwr_n}, 8'h01);
    cmd(1'b1, 8'h10, 8'h00);
    chk(m_rdata, 8'h80);
    $display("test write_read done");
    // Reserved and read-only places
    cmd(1'b0, 8'h11, 8'h77);
    chk(8'(stb_cnt_a), 8'h02);
    cmd(1'b1, 8'h11, 8'h00);
    chk(m_rdata, 8'h00);
    cmd(1'b1, 8'hFF, 8'h00);
    chk(m_rdata, DEVICE_REVISION);
    chk({7'h00, busy_a}, 8'h00);
    $display("test reserved done");
    // Foreign address: nack, rest of the frame ignored
    bb_start();
    bw(8'h30, 1'b1);
    bw(8'h00, 1'b1);
    bb_stop();
    // Burst write from register 0x00
    bb_start();
    bw(8'h20, 1'b0);
    bw(8'h00, 1'b0);
    bw(8'h11, 1'b0);
    bw(8'h22, 1'b0);
    bb_stop();
    chk(8'(stb_cnt_b), 8'h02);
    chk(waddr_b, 8'h01);
    chk(wdata_b, 8'h22);
    // STOP in the middle of a data byte
    bb_start();
    bw(8'h20, 1'b0);
    bw(8'h05, 1'b0);
    bb_byte(8'hAB, 1'b1, 4, g8, a1);
    bb_stop();
    chk(8'(stb_cnt_b), 8'h02);
    chk({7'h00, busy_b}, 8'h00);
    $display("test link faults done");
    // Sequential read after plain START, then again after STOP
    bb_start();
    bw(8'h21, 1'b0);
    br(1'b0, 8'h11);
    br(1'b1, 8'h22);
    bb_stop();
    bb_start();
    bw(8'h21, 1'b0);
    br(1'b1, 8'h11);
    bb_stop();
    // Random read through a repeated START
    bb_start();
    bw(8'h20, 1'b0);
    bw(8'h01, 1'b0);
    bb_start();
    bw(8'h21, 1'b0);
    br(1'b1, 8'h22);
    bb_stop();
    $display("test reads done");
    close_out();
  end
endmodule : i2c_slave_register_port_tb_top
`default_nettype wire
